// ---- rsc_defines.svh ----
// Behaviour
// [RULE1] chip power-down bit: one powers chip down, zero runs; resets to one.
// [RULE2] secondary loop takes primary's active reference at zero, input c at one.
// [RULE3] each of three receivers has a power-down bit, one powers it down.
// [RULE4] two-bit receiver format: 00 cmos, 01 ac differential, 10 crystal; 11 unused.
// [RULE5] switchover style bit 3: zero bounded transient, one immediate; resets zero.
// [RULE6] software enables monitor and crystal formats on a and b before redundancy.
// [RULE7] select-source bit picks pin at zero, software select bit at one.
// [RULE8] redundancy switchover enabled overrides select source: pin and software ignored.
// [RULE9] software select bit 0 picks input a at zero, input b at one.
// [RULE10] software select bit counts only while select source is one.
// [RULE11] monitor enable at bit 7 of next register, input c as standard.
// [RULE12] reserved bits read zero and writes to them change nothing.
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

`define RSC_OFF_CHIP_MODE    12'h040
`define RSC_OFF_REF_AB       12'h080
`define RSC_OFF_REF_C        12'h081
`define RSC_OFF_SWITCH       12'h082
`define RSC_OFF_MONITOR      12'h083
`define RSC_OFF_STATUS       12'h084

`define RSC_BIT_CHIP_PD      1
`define RSC_BIT_SEC_REF      0
`define RSC_BIT_PD_B         6
`define RSC_POS_FMT_B        4
`define RSC_BIT_PD_A         2
`define RSC_POS_FMT_A        0
`define RSC_BIT_PD_C         2
`define RSC_POS_FMT_C        0
`define RSC_BIT_SMOOTH_DIS   3
`define RSC_BIT_CRYSTAL_INPUT_RED     2
`define RSC_BIT_SOFT_SRC     1
`define RSC_BIT_SOFT_SEL     0
`define RSC_BIT_MON_EN       7
`define RSC_BIT_MON_FREQ     5
`define RSC_BIT_MON_8K       4
`define RSC_POS_MON_CLK      2
`define RSC_POS_MON_WIN      0

`define RSC_RST_CHIP_PD      1'b1
`define RSC_RST_BIT          1'b0
`define RSC_RST_FIELD        2'h0

`define RSC_CLK_PERIOD_NS    4
`define RSC_SETTLE_NS        100
`define RSC_SETTLE_CYC       ((`RSC_SETTLE_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)

`endif

// ---- rsc_pkg.sv ----
`default_nettype none
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_FMT_CMOS    = 2'h0,
    RSC_FMT_AC_DIFF = 2'h1,
    RSC_FMT_CRYSTAL_INPUT    = 2'h2,
    RSC_FMT_RSVD    = 2'h3
  } rsc_fmt_t;

  typedef enum logic [1:0] {
    RSC_REF_A = 2'h0,
    RSC_REF_B = 2'h1,
    RSC_REF_C = 2'h2
  } rsc_ref_t;

  typedef enum logic [1:0] {
    RSC_SRC_PIN  = 2'h0,
    RSC_SRC_SOFT = 2'h1,
    RSC_SRC_AUTO = 2'h2
  } rsc_src_t;

  typedef struct packed {
    logic     powerDown;
    rsc_fmt_t format;
  } rsc_rx_t;

  typedef struct packed {
    logic       enable;
    logic       freq1944;
    logic       mode8k;
    logic [1:0] clkFreq;
    logic [1:0] errWindow;
  } rsc_mon_t;

endpackage
`default_nettype wire

// ---- rsc_sync2.sv ----
`default_nettype none
module rsc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // level in and out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule
`default_nettype wire

// ---- rsc_reg_bank.sv ----
// The address-and-strobe port was left to the implementer.
`include "rsc_defines.svh"
`default_nettype none
module rsc_reg_bank #(
  parameter int ADDR_W     = 12,
  parameter int SETTLE_CYC = `RSC_SETTLE_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // register port
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  output logic      [7:0]          regRdData,
  // select pin and monitor choice
  input  wire logic                refSelPin,
  input  wire logic                autoRefSel,
  // chip and receiver control
  output logic                     chipPowerDown,
  output rsc_pkg::rsc_rx_t         rxCfgA,
  output rsc_pkg::rsc_rx_t         rxCfgB,
  output rsc_pkg::rsc_rx_t         rxCfgC,
  // loop reference routing
  output rsc_pkg::rsc_ref_t        primaryRef,
  output rsc_pkg::rsc_ref_t        secondaryRef,
  output rsc_pkg::rsc_src_t        selSource,
  output logic                     immediateSwitch,
  output logic                     switchActive,
  output logic                     xtalRedundEn,
  // reference monitor setup
  output rsc_pkg::rsc_mon_t        monCfg
);
  import rsc_pkg::*;

  typedef enum {
    ST_STEADY,
    ST_SETTLE
  } rsc_state_t;

  localparam int CNT_W = $clog2(SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC - 1);
  localparam logic [ADDR_W-1:0] A_CHIP = ADDR_W'(`RSC_OFF_CHIP_MODE);
  localparam logic [ADDR_W-1:0] A_AB   = ADDR_W'(`RSC_OFF_REF_AB);
  localparam logic [ADDR_W-1:0] A_C    = ADDR_W'(`RSC_OFF_REF_C);
  localparam logic [ADDR_W-1:0] A_SW   = ADDR_W'(`RSC_OFF_SWITCH);
  localparam logic [ADDR_W-1:0] A_MON  = ADDR_W'(`RSC_OFF_MONITOR);
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`RSC_OFF_STATUS);

  // stored control
  logic             chipPd_q;
  logic             secRefC_q;
  logic             pdA_q;
  logic             pdB_q;
  logic             pdC_q;
  logic [1:0]       fmtA_q;
  logic [1:0]       fmtB_q;
  logic [1:0]       fmtC_q;
  logic             smoothDis_q;
  logic             xtalRed_q;
  logic             softSrc_q;
  logic             softSel_q;
  logic             monEn_q;
  logic             monFreq_q;
  logic             mon8k_q;
  logic [1:0]       monClk_q;
  logic [1:0]       monWin_q;

  // switchover state
  rsc_state_t       state_q;
  rsc_state_t       state_d;
  logic             curSel_q;
  logic             curSel_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [7:0]       rdData_q;

  // decode
  wire logic        hitChip;
  wire logic        hitAb;
  wire logic        hitC;
  wire logic        hitSw;
  wire logic        hitMon;
  wire logic        hitStat;
  wire logic        wrChip;
  wire logic        wrAb;
  wire logic        wrC;
  wire logic        wrSw;
  wire logic        wrMon;
  wire logic        pinSel;
  wire logic        reqSel;
  wire logic        selDiffers;
  wire logic        settleDone;
  wire logic        fmtReserved;
  wire logic        redundPrereqMiss;
  wire rsc_src_t    srcNow;
  wire logic [7:0]  regChipVal;
  wire logic [7:0]  regAbVal;
  wire logic [7:0]  regCVal;
  wire logic [7:0]  regSwVal;
  wire logic [7:0]  regMonVal;
  wire logic [7:0]  regStatVal;
  wire logic [7:0]  rdMux;

  // write data split into fields
  wire logic        wdChipPd;
  wire logic        wdSecRef;
  wire logic        wdPdA;
  wire logic        wdPdB;
  wire logic        wdPdC;
  wire logic [1:0]  wdFmtA;
  wire logic [1:0]  wdFmtB;
  wire logic [1:0]  wdFmtC;
  wire logic        wdSmoothDis;
  wire logic        wdXtalRed;
  wire logic        wdSoftSrc;
  wire logic        wdSoftSel;
  wire logic        wdMonEn;
  wire logic        wdMonFreq;
  wire logic        wdMon8k;
  wire logic [1:0]  wdMonClk;
  wire logic [1:0]  wdMonWin;

  // two flops on the select pin before use
  rsc_sync2 #(
    .W       (1)
  ) u_pin_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn (refSelPin),
    .syncOut (pinSel)
  );

  assign hitChip = (regAddr == A_CHIP);
  assign hitAb   = (regAddr == A_AB);
  assign hitC    = (regAddr == A_C);
  assign hitSw   = (regAddr == A_SW);
  assign hitMon  = (regAddr == A_MON);
  assign hitStat = (regAddr == A_STAT);

  assign wrChip = regWrEn & hitChip;
  assign wrAb   = regWrEn & hitAb;
  assign wrC    = regWrEn & hitC;
  assign wrSw   = regWrEn & hitSw;
  assign wrMon  = regWrEn & hitMon;

  assign wdChipPd    = regWrData[`RSC_BIT_CHIP_PD];
  assign wdSecRef    = regWrData[`RSC_BIT_SEC_REF];
  assign wdPdA       = regWrData[`RSC_BIT_PD_A];
  assign wdPdB       = regWrData[`RSC_BIT_PD_B];
  assign wdPdC       = regWrData[`RSC_BIT_PD_C];
  assign wdFmtA      = regWrData[`RSC_POS_FMT_A +: 2];
  assign wdFmtB      = regWrData[`RSC_POS_FMT_B +: 2];
  assign wdFmtC      = regWrData[`RSC_POS_FMT_C +: 2];
  assign wdSmoothDis = regWrData[`RSC_BIT_SMOOTH_DIS];
  assign wdXtalRed   = regWrData[`RSC_BIT_CRYSTAL_INPUT_RED];
  assign wdSoftSrc   = regWrData[`RSC_BIT_SOFT_SRC];
  assign wdSoftSel   = regWrData[`RSC_BIT_SOFT_SEL];
  assign wdMonEn     = regWrData[`RSC_BIT_MON_EN];
  assign wdMonFreq   = regWrData[`RSC_BIT_MON_FREQ];
  assign wdMon8k     = regWrData[`RSC_BIT_MON_8K];
  assign wdMonClk    = regWrData[`RSC_POS_MON_CLK +: 2];
  assign wdMonWin    = regWrData[`RSC_POS_MON_WIN +: 2];

  // only defined bits are stored; the rest read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chipPd_q  <= `RSC_RST_CHIP_PD; // see [RULE1]
      secRefC_q <= `RSC_RST_BIT; // see [RULE2]
    end else if (wrChip) begin
      chipPd_q  <= wdChipPd; // see [RULE1]
      secRefC_q <= wdSecRef; // see [RULE2]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pdA_q  <= `RSC_RST_BIT;
      pdB_q  <= `RSC_RST_BIT;
      fmtA_q <= `RSC_RST_FIELD;
      fmtB_q <= `RSC_RST_FIELD;
    end else if (wrAb) begin
      pdA_q  <= wdPdA; // see [RULE3]
      pdB_q  <= wdPdB; // see [RULE3]
      fmtA_q <= wdFmtA; // see [RULE4]
      fmtB_q <= wdFmtB; // see [RULE4]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pdC_q  <= `RSC_RST_BIT;
      fmtC_q <= `RSC_RST_FIELD;
    end else if (wrC) begin
      pdC_q  <= wdPdC; // see [RULE3]
      fmtC_q <= wdFmtC; // see [RULE4]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smoothDis_q <= `RSC_RST_BIT;
      xtalRed_q   <= `RSC_RST_BIT;
      softSrc_q   <= `RSC_RST_BIT;
      softSel_q   <= `RSC_RST_BIT;
    end else if (wrSw) begin
      smoothDis_q <= wdSmoothDis; // see [RULE5]
      xtalRed_q   <= wdXtalRed;
      softSrc_q   <= wdSoftSrc; // see [RULE7]
      softSel_q   <= wdSoftSel; // see [RULE9]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      monEn_q   <= `RSC_RST_BIT;
      monFreq_q <= `RSC_RST_BIT;
      mon8k_q   <= `RSC_RST_BIT;
      monClk_q  <= `RSC_RST_FIELD;
      monWin_q  <= `RSC_RST_FIELD;
    end else if (wrMon) begin
      monEn_q   <= wdMonEn; // see [RULE11]
      monFreq_q <= wdMonFreq;
      mon8k_q   <= wdMon8k;
      monClk_q  <= wdMonClk;
      monWin_q  <= wdMonWin;
    end
  end

  // requested primary select
  assign srcNow = xtalRed_q ? RSC_SRC_AUTO : // see [RULE8]
                  (softSrc_q ? RSC_SRC_SOFT : RSC_SRC_PIN); // see [RULE7]
  assign reqSel = (srcNow == RSC_SRC_AUTO) ? autoRefSel :
                  (srcNow == RSC_SRC_SOFT) ? softSel_q : // see [RULE10]
                  pinSel;

  assign selDiffers = (reqSel != curSel_q);
  assign settleDone = (cnt_q == '0);

  // smooth mode waits out the settle time before handing over
  always_comb begin
    state_d  = state_q;
    curSel_d = curSel_q;
    cnt_d    = cnt_q;
    unique case (state_q)
      ST_STEADY: begin
        if (selDiffers && smoothDis_q) begin
          curSel_d = reqSel; // see [RULE5]
        end else if (selDiffers) begin
          state_d = ST_SETTLE; // see [RULE5]
          cnt_d   = SETTLE_LOAD;
        end
      end
      ST_SETTLE: begin
        if (!selDiffers) begin
          state_d = ST_STEADY;
        end else if (smoothDis_q || settleDone) begin
          curSel_d = reqSel;
          state_d  = ST_STEADY;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= ST_STEADY;
      curSel_q <= 1'b0;
      cnt_q    <= '0;
    end else begin
      state_q  <= state_d;
      curSel_q <= curSel_d;
      cnt_q    <= cnt_d;
    end
  end

  // diagnostics for software
  assign fmtReserved = (fmtA_q == RSC_FMT_RSVD) |
                       (fmtB_q == RSC_FMT_RSVD) |
                       (fmtC_q == RSC_FMT_RSVD);
  assign redundPrereqMiss = xtalRed_q &
                            (!monEn_q |
                             (fmtA_q != RSC_FMT_CRYSTAL_INPUT) |
                             (fmtB_q != RSC_FMT_CRYSTAL_INPUT)); // see [RULE6]

  // read values, reserved positions zero
  assign regChipVal = {6'h00, chipPd_q, secRefC_q}; // see [RULE12]
  assign regAbVal   = {1'b0, pdB_q, fmtB_q, 1'b0, pdA_q, fmtA_q}; // see [RULE12]
  assign regCVal    = {5'h00, pdC_q, fmtC_q}; // see [RULE12]
  assign regSwVal   = {4'h0, smoothDis_q, xtalRed_q, softSrc_q, softSel_q}; // see [RULE12]
  assign regMonVal  = {monEn_q, 1'b0, monFreq_q, mon8k_q, monClk_q, monWin_q}; // see [RULE12]
  assign regStatVal = {1'b0, redundPrereqMiss, fmtReserved, pinSel,
                       srcNow, switchActive, curSel_q};

  assign rdMux = hitChip ? regChipVal :
                 hitAb   ? regAbVal   :
                 hitC    ? regCVal    :
                 hitSw   ? regSwVal   :
                 hitMon  ? regMonVal  :
                 hitStat ? regStatVal :
                 8'h00;

  // read data stands one cycle only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 8'h00;
    end else if (regRdEn) begin
      rdData_q <= rdMux;
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign regRdData = rdData_q;

  // outputs; chip power-down also powers every receiver down
  assign chipPowerDown = chipPd_q; // see [RULE1]

  assign rxCfgA.powerDown = pdA_q | chipPd_q; // see [RULE3]
  assign rxCfgA.format    = rsc_fmt_t'(fmtA_q); // see [RULE4]
  assign rxCfgB.powerDown = pdB_q | chipPd_q; // see [RULE3]
  assign rxCfgB.format    = rsc_fmt_t'(fmtB_q); // see [RULE4]
  assign rxCfgC.powerDown = pdC_q | chipPd_q; // see [RULE3]
  assign rxCfgC.format    = rsc_fmt_t'(fmtC_q); // see [RULE4]

  assign primaryRef   = curSel_q ? RSC_REF_B : RSC_REF_A; // see [RULE9]
  assign secondaryRef = secRefC_q ? RSC_REF_C : primaryRef; // see [RULE2]
  assign selSource    = srcNow;

  assign immediateSwitch = smoothDis_q; // see [RULE5]
  assign switchActive    = (state_q == ST_SETTLE);
  assign xtalRedundEn    = xtalRed_q; // see [RULE8]

  assign monCfg.enable    = monEn_q; // see [RULE11]
  assign monCfg.freq1944  = monFreq_q;
  assign monCfg.mode8k    = mon8k_q;
  assign monCfg.clkFreq   = monClk_q;
  assign monCfg.errWindow = monWin_q;

endmodule
`default_nettype wire

// ---- rsc_reg_bank_properties.sv ----
`include "rsc_defines.svh"
`default_nettype none
module rsc_reg_bank_checker #(
  parameter int ADDR_W     = 12,
  parameter int SETTLE_CYC = 2
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regWrData,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [7:0]        regRdData,
  // select inputs
  input wire logic              refSelPin,
  input wire logic              autoRefSel,
  // control outputs
  input wire logic              chipPowerDown,
  input wire rsc_pkg::rsc_rx_t  rxCfgA,
  input wire rsc_pkg::rsc_rx_t  rxCfgB,
  input wire rsc_pkg::rsc_rx_t  rxCfgC,
  input wire rsc_pkg::rsc_ref_t primaryRef,
  input wire rsc_pkg::rsc_ref_t secondaryRef,
  input wire rsc_pkg::rsc_src_t selSource,
  input wire logic              immediateSwitch,
  input wire logic              switchActive,
  input wire logic              xtalRedundEn,
  input wire rsc_pkg::rsc_mon_t monCfg
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  wire wrChip = regWrEn && regAddr == `RSC_OFF_CHIP_MODE;
  wire wrAb   = regWrEn && regAddr == `RSC_OFF_REF_AB;
  wire wrC    = regWrEn && regAddr == `RSC_OFF_REF_C;
  wire wrSw   = regWrEn && regAddr == `RSC_OFF_SWITCH;
  wire wrMon  = regWrEn && regAddr == `RSC_OFF_MONITOR;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_chip_pd_all: assert property (
    chipPowerDown |-> rxCfgA.powerDown && rxCfgB.powerDown && rxCfgC.powerDown) else $error("receiver not down");
  a_chip_pd_write: assert property (
    wrChip |=> chipPowerDown == $past(regWrData[1])) else $error("chip power-down wrong");
  a_sec_ref_route: assert property (
    wrChip |=> secondaryRef == ($past(regWrData[0]) ? RSC_REF_C : primaryRef)) else $error("secondary ref wrong");
  a_rx_ab_write: assert property (
    wrAb |=> rxCfgB == {$past(regWrData[6]) | chipPowerDown, $past(regWrData[5:4])}
      && rxCfgA == {$past(regWrData[2]) | chipPowerDown, $past(regWrData[1:0])}) else $error("rx a b wrong");
  a_rx_c_write: assert property (
    wrC |=> rxCfgC == {$past(regWrData[2]) | chipPowerDown, $past(regWrData[1:0])}) else $error("rx c wrong");
  a_style_write: assert property (
    wrSw |=> immediateSwitch == $past(regWrData[3]) && xtalRedundEn == $past(regWrData[2]))
    else $error("switch style wrong");
  a_sel_source: assert property (
    wrSw |=> selSource == ($past(regWrData[2]) ? RSC_SRC_AUTO : $past(regWrData[1]) ? RSC_SRC_SOFT : RSC_SRC_PIN))
    else $error("select source wrong");
  a_soft_select: assert property (
    wrSw && regWrData[3:1] == 3'b101 |-> ##2 primaryRef == ($past(regWrData[0], 2) ? RSC_REF_B : RSC_REF_A))
    else $error("soft select wrong");
  a_rsvd_read: assert property (
    regRdEn && regAddr == `RSC_OFF_SWITCH |=> regRdData[7:4] == 4'h0) else $error("reserved bits set");
  a_mon_enable: assert property (
    wrMon |=> monCfg.enable == $past(regWrData[7])) else $error("monitor enable wrong");
  a_settle_hold: assert property (
    switchActive |-> $stable(primaryRef)) else $error("reference moved during settle");
endmodule
bind rsc_reg_bank rsc_reg_bank_checker #(.ADDR_W(ADDR_W), .SETTLE_CYC(SETTLE_CYC)) uChk (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .refSelPin(refSelPin), .autoRefSel(autoRefSel),
  .chipPowerDown(chipPowerDown), .rxCfgA(rxCfgA), .rxCfgB(rxCfgB), .rxCfgC(rxCfgC),
  .primaryRef(primaryRef), .secondaryRef(secondaryRef), .selSource(selSource),
  .immediateSwitch(immediateSwitch), .switchActive(switchActive), .xtalRedundEn(xtalRedundEn),
  .monCfg(monCfg));
`default_nettype wire

// ---- test_rsc_reg_bank.sv ----
`include "rsc_defines.svh"
`default_nettype none
module test_rsc_reg_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  localparam int SC = 2;
  logic        clk, arst_n, regWrEn, regRdEn, refSelPin, autoRefSel;
  logic        chipPowerDown, immediateSwitch, switchActive, xtalRedundEn;
  logic [11:0] regAddr;
  logic [7:0]  regWrData, regRdData;
  rsc_rx_t     rxCfgA, rxCfgB, rxCfgC;
  rsc_ref_t    primaryRef, secondaryRef;
  rsc_src_t    selSource;
  rsc_mon_t    monCfg;
  int          nFail = 0;
  int          nCompared = 0;

  rsc_reg_bank #(.ADDR_W(12), .SETTLE_CYC(SC)) DUT (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .refSelPin(refSelPin), .autoRefSel(autoRefSel),
    .chipPowerDown(chipPowerDown), .rxCfgA(rxCfgA), .rxCfgB(rxCfgB), .rxCfgC(rxCfgC),
    .primaryRef(primaryRef), .secondaryRef(secondaryRef), .selSource(selSource),
    .immediateSwitch(immediateSwitch), .switchActive(switchActive), .xtalRedundEn(xtalRedundEn),
    .monCfg(monCfg));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk("regRdData", exp, regRdData);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic ref_is(input rsc_ref_t exp);
    chk("primaryRef", {6'h00, exp}, {6'h00, primaryRef});
  endtask

  task automatic endSim;
    if (nFail == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    nFail++;
    endSim();
  end

  initial begin
    {arst_n, regWrEn, regRdEn, refSelPin, autoRefSel} = 5'h00;
    regAddr   = 12'h000;
    regWrData = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(`RSC_OFF_CHIP_MODE, 8'h02);
    chk("rxPowerDown", 8'h07, {5'h00, rxCfgA.powerDown, rxCfgB.powerDown, rxCfgC.powerDown});
    rd(`RSC_OFF_REF_AB, 8'h00);
    rd(`RSC_OFF_REF_C, 8'h00);
    rd(`RSC_OFF_SWITCH, 8'h00);
    wr(`RSC_OFF_CHIP_MODE, 8'hff);
    chk("secondaryRef", {6'h00, RSC_REF_C}, {6'h00, secondaryRef});
    rd(`RSC_OFF_CHIP_MODE, 8'h03);
    wr(`RSC_OFF_CHIP_MODE, 8'h00);
    chk("chipPowerDown", 8'h00, {7'h00, chipPowerDown});
    chk("secondaryRef", {6'h00, RSC_REF_A}, {6'h00, secondaryRef});
    // every legal format, power-down bits in opposite senses
    for (int f = 0; f < 3; f++) begin
      wr(`RSC_OFF_REF_AB, {1'b0, f[0], f[1:0], 1'b0, ~f[0], f[1:0]});
      wr(`RSC_OFF_REF_C, {5'h00, f[0], f[1:0]});
      chk("rxCfgA", {5'h00, ~f[0], f[1:0]}, {5'h00, rxCfgA});
      chk("rxCfgB", {5'h00, f[0], f[1:0]}, {5'h00, rxCfgB});
      chk("rxCfgC", {5'h00, f[0], f[1:0]}, {5'h00, rxCfgC});
    end
    // reserved positions set, formats kept legal
    wr(`RSC_OFF_REF_AB, 8'hee);
    rd(`RSC_OFF_REF_AB, 8'h66);
    wr(`RSC_OFF_REF_C, 8'hfe);
    rd(`RSC_OFF_REF_C, 8'h06);
    wr(12'h085, 8'hff);
    rd(12'h085, 8'h00);
    // redundancy stays off until monitor and crystal formats are set
    wr(`RSC_OFF_SWITCH, 8'hfb);
    rd(`RSC_OFF_SWITCH, 8'h0b);
    chk("selSource", {6'h00, RSC_SRC_SOFT}, {6'h00, selSource});
    wr(`RSC_OFF_SWITCH, 8'h08);
    @(posedge clk);
    refSelPin <= 1'b1;
    cyc(5);
    ref_is(RSC_REF_B);
    wr(`RSC_OFF_SWITCH, 8'h0a);
    cyc(3);
    ref_is(RSC_REF_A);
    wr(`RSC_OFF_SWITCH, 8'h0b);
    cyc(3);
    ref_is(RSC_REF_B);
    @(posedge clk);
    refSelPin <= 1'b0;
    cyc(5);
    ref_is(RSC_REF_B);
    wr(`RSC_OFF_MONITOR, 8'hff);
    rd(`RSC_OFF_MONITOR, 8'hbf);
    chk("monEnable", 8'h01, {7'h00, monCfg.enable});
    chk("monCfg", 8'h7f, {1'b0, monCfg});
    wr(`RSC_OFF_REF_AB, 8'h22);
    wr(`RSC_OFF_SWITCH, 8'h0e);
    chk("selSource", {6'h00, RSC_SRC_AUTO}, {6'h00, selSource});
    chk("xtalRedundEn", 8'h01, {7'h00, xtalRedundEn});
    @(posedge clk);
    autoRefSel <= 1'b1;
    cyc(3);
    ref_is(RSC_REF_B);
    @(posedge clk);
    autoRefSel <= 1'b0;
    wr(`RSC_OFF_SWITCH, 8'h0f);
    cyc(3);
    ref_is(RSC_REF_A);
    // smooth change: settle window before the new reference lands
    wr(`RSC_OFF_SWITCH, 8'h02);
    cyc(SC + 3);
    wr(`RSC_OFF_SWITCH, 8'h03);
    cyc(1);
    chk("switchActive", 8'h01, {7'h00, switchActive});
    ref_is(RSC_REF_A);
    cyc(SC);
    ref_is(RSC_REF_B);
    chk("switchActive", 8'h00, {7'h00, switchActive});
    rd(`RSC_OFF_STATUS, 8'h05);
    // reset again in mid-run: everything back to its reset value
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(`RSC_OFF_CHIP_MODE, 8'h02);
    rd(`RSC_OFF_SWITCH, 8'h00);
    ref_is(RSC_REF_A);
    endSim();
  end
endmodule
`default_nettype wire
